/* File: core/nbi_fifo.sv */
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module nbi_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic      [WIDTH-1:0] out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  always_comb begin
    push        = in_valid_i && (count != (AW+1)'(DEPTH));
    pop         = out_ready_i && (count != '0);
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count  = count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  assign in_ready_o  = (count != (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o  = mem[rd_ptr];
endmodule
`default_nettype wire

/* File: core/nbi_host.sv */
// Host controller that drives a NAND flash through its bus pins.
// Assumes synchronous pin inputs; read words are buffered in a FIFO.
`timescale 1ns/1ps
`default_nettype none
module nbi_host
  import nbi_pkg::*;
#(
  parameter int DATA_W     = 16,
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic              clk_i,
  input  wire logic              reset_i,
  input  wire logic [18:0]       req_i,
  input  wire logic              req_valid_i,
  output logic                   req_ready_o,
  input  wire logic              write_enable_i,
  input  wire logic              spare_excl_i,
  output logic [DATA_W-1:0]      rd_data_o,
  output logic                   rd_valid_o,
  input  wire logic              rd_ready_i,
  output logic                   busy_o,
  output logic                   chip_select_n_o,
  output logic                   cmd_latch_sel_o,
  output logic                   addr_latch_sel_o,
  output logic                   input_strobe_n_o,
  output logic                   output_strobe_n_o,
  output logic                   program_lock_n_o,
  output logic                   spare_area_sel_o,
  output logic [DATA_W-1:0]      bus_o,
  output logic [DATA_W-1:0]      bus_oe_o,
  input  wire logic [DATA_W-1:0] bus_i,
  input  wire logic              busy_flag_n_i
);
  nbi_req_s         req;
  nbi_req_s         cur;
  nbi_req_s         next_cur;
  nbi_state_e       state;
  nbi_state_e       next_state;
  logic [9:0]       cnt;
  logic [9:0]       next_cnt;
  logic             next_ready;
  logic             next_cs_n;
  logic             next_cle;
  logic             next_ale;
  logic             next_we_n;
  logic             next_os_n;
  logic             next_lock_n;
  logic [DATA_W-1:0] next_bus;
  logic [DATA_W-1:0] next_oe;
  logic [DATA_W-1:0] cap;
  logic [DATA_W-1:0] next_cap;
  logic             push;
  logic             fifo_in_ready;
  logic             fifo_out_valid;
  logic [DATA_W-1:0] fifo_out_data;
  logic             next_rd_valid;
  logic [DATA_W-1:0] next_rd_data;
  logic             fifo_pop;

  assign req = nbi_req_s'(req_i);

  function automatic logic is_low_byte_op(input logic [1:0] op);
    return (op == NBI_OP_CMD) || (op == NBI_OP_ADDR);
  endfunction

  always_comb begin
    next_state  = state;
    next_cur    = cur;
    next_cnt    = (cnt != '0) ? cnt - 10'h001 : cnt;
    next_ready  = 1'b0;
    next_cs_n   = chip_select_n_o;
    next_cle    = cmd_latch_sel_o;
    next_ale    = addr_latch_sel_o;
    next_we_n   = input_strobe_n_o;
    next_os_n   = output_strobe_n_o;
    next_bus    = bus_o;
    next_oe     = bus_oe_o;
    next_cap    = cap;
    push        = 1'b0;
    // lock high only when writes enabled
    next_lock_n = (state != NBI_ST_RECOVER) && write_enable_i;
    case (state)
      NBI_ST_RECOVER: begin
        // wait out 1us with strobe high
        next_we_n = 1'b1;
        next_os_n = 1'b1;
        if (cnt == '0) begin
          next_state = NBI_ST_IDLE;
          next_ready = 1'b1;
        end
      end
      NBI_ST_IDLE: begin
        next_ready = 1'b1;
        if (!cur.hold_sel) begin
          next_cs_n = 1'b1;
        end
        next_cle = 1'b0;
        next_ale = 1'b0;
        next_oe  = '0;
        if (req_valid_i && req_ready_o) begin
          next_ready = 1'b0;
          next_cur   = req;
          next_cs_n  = 1'b0;
          next_cle   = (req.op == NBI_OP_CMD);
          next_ale   = (req.op == NBI_OP_ADDR);
          next_bus   = is_low_byte_op(req.op) ? {{(DATA_W-8){1'b0}}, req.word[7:0]}
                                              : req.word[DATA_W-1:0];
          next_oe    = (req.op == NBI_OP_RDATA) ? '0 : '1;
          next_cnt   = 10'(NBI_STROBE_LOW_CYC);
          next_state = NBI_ST_LOW;
        end
      end
      NBI_ST_LOW: begin
        if (cur.op == NBI_OP_RDATA) begin
          next_os_n = 1'b0;
        end else begin
          next_we_n = 1'b0;
        end
        // Sample only once the strobe has really been low for the full phase
        if (cnt == '0 && next_os_n == output_strobe_n_o && next_we_n == input_strobe_n_o) begin
          next_cap   = bus_i;
          next_we_n  = 1'b1;
          next_os_n  = 1'b1;
          next_cnt   = 10'(NBI_STROBE_HI_CYC);
          next_state = (cur.op == NBI_OP_RDATA) ? NBI_ST_PUSH : NBI_ST_HIGH;
        end
      end
      NBI_ST_PUSH: begin
        if (fifo_in_ready) begin
          push       = 1'b1;
          next_state = NBI_ST_HIGH;
        end
      end
      NBI_ST_HIGH: begin
        if (cnt == '0) begin
          next_state = NBI_ST_IDLE;
          next_ready = 1'b1;
        end
      end
      default: begin
        next_state = NBI_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state             <= NBI_ST_RECOVER;
      cur               <= '0;
      cnt               <= 10'(NBI_RECOVERY_CYC);
      req_ready_o       <= 1'b0;
      chip_select_n_o   <= 1'b1;
      cmd_latch_sel_o   <= 1'b0;
      addr_latch_sel_o  <= 1'b0;
      input_strobe_n_o  <= 1'b1;
      output_strobe_n_o <= 1'b1;
      program_lock_n_o  <= 1'b0;
      bus_o             <= '0;
      bus_oe_o          <= '0;
      cap               <= '0;
    end else begin
      state             <= next_state;
      cur               <= next_cur;
      cnt               <= next_cnt;
      req_ready_o       <= next_ready;
      chip_select_n_o   <= next_cs_n;
      cmd_latch_sel_o   <= next_cle;
      addr_latch_sel_o  <= next_ale;
      input_strobe_n_o  <= next_we_n;
      output_strobe_n_o <= next_os_n;
      program_lock_n_o  <= next_lock_n;
      bus_o             <= next_bus;
      bus_oe_o          <= next_oe;
      cap               <= next_cap;
    end
  end

  // Sample pins straight into flops; busy is shared wired-AND
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      // any low means some device busy
      busy_o           <= 1'b0;
      spare_area_sel_o <= 1'b0;
    end else begin
      busy_o           <= !busy_flag_n_i;
      spare_area_sel_o <= spare_excl_i;
    end
  end

  nbi_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .reset_i     (reset_i),
    .in_data_i   (cap),
    .in_valid_i  (push),
    .in_ready_o  (fifo_in_ready),
    .out_data_o  (fifo_out_data),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_pop)
  );

  // Output skid register keeps rd_* straight from flops
  always_comb begin
    fifo_pop      = fifo_out_valid && (!rd_valid_o || rd_ready_i);
    next_rd_valid = rd_valid_o && !rd_ready_i;
    next_rd_data  = rd_data_o;
    if (fifo_pop) begin
      next_rd_valid = 1'b1;
      next_rd_data  = fifo_out_data;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rd_valid_o <= 1'b0;
      rd_data_o  <= '0;
    end else begin
      rd_valid_o <= next_rd_valid;
      rd_data_o  <= next_rd_data;
    end
  end

  latch_excl_a: assert property (@(posedge clk_i) disable iff (reset_i)
    !(cmd_latch_sel_o && addr_latch_sel_o)) else $error("both latch selects high");
  recover_quiet_a: assert property (@(posedge clk_i) disable iff (reset_i)
    state == NBI_ST_RECOVER |-> input_strobe_n_o && !req_ready_o) else $error("early command");
  recover_lock_a: assert property (@(posedge clk_i) disable iff (reset_i)
    state == NBI_ST_RECOVER |=> !program_lock_n_o || $past(state) != NBI_ST_RECOVER)
    else $error("lock released in recovery");
  strobe_sel_a: assert property (@(posedge clk_i) disable iff (reset_i)
    !input_strobe_n_o |-> !chip_select_n_o && output_strobe_n_o) else $error("strobe unselected");
  read_release_a: assert property (@(posedge clk_i) disable iff (reset_i)
    !output_strobe_n_o |-> bus_oe_o == '0 && input_strobe_n_o) else $error("bus driven on read");
  low_byte_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (cmd_latch_sel_o || addr_latch_sel_o) && !input_strobe_n_o |-> bus_o[DATA_W-1:8] == '0)
    else $error("high byte used");
  out_pulse_a: assert property (@(posedge clk_i) disable iff (reset_i)
    $fell(output_strobe_n_o) |-> ##[1:4] output_strobe_n_o) else $error("read strobe stuck");
  lock_follow_a: assert property (@(posedge clk_i) disable iff (reset_i)
    state != NBI_ST_RECOVER && !write_enable_i |=> !program_lock_n_o) else $error("lock high");
  we_pulse_a: assert property (@(posedge clk_i) disable iff (reset_i)
    $fell(input_strobe_n_o) |-> ##[1:4] input_strobe_n_o) else $error("write strobe stuck");
  // write strobe low exactly two cycles
  we_width_a: assert property (@(posedge clk_i) disable iff (reset_i)
    $fell(input_strobe_n_o) |=> !input_strobe_n_o ##1 input_strobe_n_o)
    else $error("write strobe width wrong");
  hold_select_a: assert property (@(posedge clk_i) disable iff (reset_i)
    state == NBI_ST_IDLE && cur.hold_sel |-> !chip_select_n_o)
    else $error("select dropped during hold");
  busy_follow_a: assert property (@(posedge clk_i) disable iff (reset_i)
    1'b1 |=> busy_o == !$past(busy_flag_n_i))
    else $error("busy not following line");
  rd_stand_a: assert property (@(posedge clk_i) disable iff (reset_i)
    rd_valid_o && !rd_ready_i |=> rd_valid_o && $stable(rd_data_o))
    else $error("read word dropped");
  cmd_cover: cover property (@(posedge clk_i) $rose(input_strobe_n_o) && cmd_latch_sel_o);
  addr_cover: cover property (@(posedge clk_i) $rose(input_strobe_n_o) && addr_latch_sel_o);
  read_cover: cover property (@(posedge clk_i) rd_valid_o && rd_ready_i);
  hold_cover: cover property (@(posedge clk_i) state == NBI_ST_IDLE && cur.hold_sel && busy_o);
  stall_cover: cover property (@(posedge clk_i) state == NBI_ST_PUSH && !fifo_in_ready);
endmodule
`default_nettype wire

/* File: core/nbi_pkg.sv */
// Shared types and timing constants for the NAND bus host controller.
// Assumes a 100 MHz system clock; all pins are synchronous to it.
package nbi_pkg;
  localparam int          NBI_CLK_PERIOD_NS  = 10;
  localparam int          NBI_RECOVERY_NS    = 1000;
  localparam int          NBI_RECOVERY_CYC   = (NBI_RECOVERY_NS + NBI_CLK_PERIOD_NS - 1)
                                               / NBI_CLK_PERIOD_NS;
  localparam int          NBI_STROBE_LOW_CYC = 2;
  localparam int          NBI_STROBE_HI_CYC  = 2;
  localparam int          NBI_ADDR_CYCLES    = 3;
  localparam logic [1:0]  NBI_OP_CMD         = 2'h0;
  localparam logic [1:0]  NBI_OP_ADDR        = 2'h1;
  localparam logic [1:0]  NBI_OP_WDATA       = 2'h2;
  localparam logic [1:0]  NBI_OP_RDATA       = 2'h3;

  typedef struct packed {
    logic [1:0]  op;
    logic        hold_sel;
    logic [15:0] word;
  } nbi_req_s;

  typedef enum logic [4:0] {
    NBI_ST_RECOVER = 5'h01,
    NBI_ST_IDLE    = 5'h02,
    NBI_ST_LOW     = 5'h04,
    NBI_ST_HIGH    = 5'h08,
    NBI_ST_PUSH    = 5'h10
  } nbi_state_e;
endpackage

/* File: verif/nbi_flash_model.sv */
// Behavioural NAND device on the host controller pins.
// Assumes pins move on host clock edges; busy is open-drain, pulled up outside.
`timescale 1ns/1ps
`default_nettype none
module nbi_flash_model #(
  parameter int MAIN_W  = 8,
  parameter int SPARE_W = 2,
  parameter int BUSY_NS = 403,
  parameter int RAMP_NS = 500
) (
  input  wire logic        chip_select_n_i,
  input  wire logic        cmd_latch_sel_i,
  input  wire logic        addr_latch_sel_i,
  input  wire logic        input_strobe_n_i,
  input  wire logic        output_strobe_n_i,
  input  wire logic        program_lock_n_i,
  input  wire logic        spare_area_sel_i,
  input  wire logic [15:0] bus_i,
  output logic      [15:0] bus_o,
  output logic             busy_pull_o
);
  localparam int TOT = MAIN_W + SPARE_W;
  logic [15:0] mem [TOT];
  logic [15:0] page [TOT];
  logic [7:0]  last_cmd;
  logic [23:0] last_addr;
  logic        reading;
  logic        powered;
  int          naddr, col, hi_errs, odd_cycles, aborts, early;
  initial begin
    bus_o       = 16'h0000;
    busy_pull_o = 1'b0;
    reading     = 1'b0;
    last_cmd    = 8'h00;
    last_addr   = 24'h000000;
    {naddr, col, hi_errs, odd_cycles, aborts, early} = '0;
    foreach (mem[i]) mem[i] = 16'h0000;
    // supply ramps past lockout some time after start
    powered = 1'b0;
    #(RAMP_NS);
    powered = 1'b1;
  end
  // busy held for the whole operation
  task automatic run_busy(input logic rd);
    reading     = rd;
    busy_pull_o = 1'b1;
    #(BUSY_NS);
    busy_pull_o = 1'b0;
    reading     = 1'b0;
  endtask
  always @(posedge input_strobe_n_i) begin
    if (!powered) begin
      // below lockout every cycle is ignored; reset edges from X are not counted
      if (chip_select_n_i === 1'b0) early++;
    end else if (chip_select_n_i || (cmd_latch_sel_i && addr_latch_sel_i) || !output_strobe_n_i) begin
      odd_cycles++;
    end else if (cmd_latch_sel_i) begin
      if (bus_i[15:8] !== 8'h00) hi_errs++;
      last_cmd = bus_i[7:0];
      naddr    = 0;
      col      = 0;
      if (last_cmd == 8'h10 && program_lock_n_i) begin
        fork
          begin
            run_busy(1'b0);
            if (program_lock_n_i) mem = page;
          end
        join_none
      end
    end else if (addr_latch_sel_i) begin
      if (bus_i[15:8] !== 8'h00) hi_errs++;
      last_addr = {bus_i[7:0], last_addr[23:8]};
      naddr++;
      if (naddr == 3 && last_cmd == 8'h00) begin
        fork
          run_busy(1'b1);
        join_none
      end
    end else if (col < TOT) begin
      page[col] = bus_i;
      col++;
    end
  end
  always @(negedge output_strobe_n_i) begin
    if (!chip_select_n_i && input_strobe_n_i && !cmd_latch_sel_i && !addr_latch_sel_i
        && !busy_pull_o && powered) begin
      bus_o = mem[col];
      col   = (col + 1) % (spare_area_sel_i ? MAIN_W : TOT);
    end
  end
  // released bus must not keep the last word
  always @(posedge output_strobe_n_i) begin
    #2;
    bus_o = ~bus_o;
  end
  // select rise during read busy aborts
  always @(posedge chip_select_n_i) begin
    if (reading) aborts++;
  end
endmodule
`default_nettype wire

/* File: verif/nbi_host_bench.sv */
// Self-checking bench for the NAND host controller.
// Assumes the device model on the pins; bus and busy resolved here.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) \
  begin \
    samples_checked++; \
    if ((g) !== (e)) begin \
      miscompares++; \
      $display("[ERR] %s expected %h seen %h", n, e, g); \
    end \
  end
module nbi_host_bench;
  import nbi_pkg::*;
  localparam int MW  = 8;
  localparam int TOT = MW + 2;
  logic        clk_i = 1'b0;
  logic        reset_i = 1'b1;
  nbi_req_s    req = '0;
  logic        req_valid = 1'b0, rd_ready = 1'b0, we = 1'b0, spx = 1'b0;
  logic        extra_busy = 1'b0, stall = 1'b1;
  logic        req_ready, rd_valid, busy, cs_n, cle, ale, ws_n, rs_n, lock_n, spare, dev_busy;
  logic [15:0] rd_data, bus_h, oe_h, bus_d, bus_w, tmp;
  logic [15:0] rnd = 16'hEBC5, rnd_r = 16'hEBC5;
  logic [23:0] exp_addr = '0;
  logic [15:0] exp_q[$];
  logic [15:0] pg [TOT];
  int          miscompares = 0, samples_checked = 0;
  always #5 clk_i = ~clk_i;
  assign bus_w = (oe_h & bus_h) | (~oe_h & bus_d);
  nbi_host #(.DATA_W(16), .FIFO_DEPTH(16)) i_nbi_host (
    .clk_i(clk_i), .reset_i(reset_i), .req_i(req), .req_valid_i(req_valid),
    .req_ready_o(req_ready), .write_enable_i(we), .spare_excl_i(spx),
    .rd_data_o(rd_data), .rd_valid_o(rd_valid), .rd_ready_i(rd_ready), .busy_o(busy),
    .chip_select_n_o(cs_n), .cmd_latch_sel_o(cle), .addr_latch_sel_o(ale),
    .input_strobe_n_o(ws_n), .output_strobe_n_o(rs_n), .program_lock_n_o(lock_n),
    .spare_area_sel_o(spare), .bus_o(bus_h), .bus_oe_o(oe_h), .bus_i(bus_w),
    // shared pull-up, any low means busy
    .busy_flag_n_i(!(dev_busy || extra_busy)));
  nbi_flash_model #(.MAIN_W(MW), .SPARE_W(2), .BUSY_NS(403)) i_nbi_flash_model (
    .chip_select_n_i(cs_n), .cmd_latch_sel_i(cle), .addr_latch_sel_i(ale),
    .input_strobe_n_i(ws_n), .output_strobe_n_i(rs_n), .program_lock_n_i(lock_n),
    .spare_area_sel_i(spare), .bus_i(bus_w), .bus_o(bus_d), .busy_pull_o(dev_busy));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  always @(negedge clk_i) begin
    rnd_r    <= lfsr(rnd_r);
    rd_ready <= !stall && rnd_r[0];
  end
  always @(posedge clk_i) begin
    if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
      `CHK("queue", 1'b1, exp_q.size() > 0)
      tmp = exp_q.pop_front();
      `CHK("rd_data", tmp, rd_data)
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic issue(input logic [1:0] op, input logic hold, input logic [15:0] w);
    int n;
    n = 0;
    @(negedge clk_i);
    while (req_ready !== 1'b1 && n < 3000) begin
      @(negedge clk_i);
      n++;
    end
    `CHK("req_taken", 1'b1, req_ready)
    req       = '{op, hold, w};
    req_valid = 1'b1;
    @(negedge clk_i);
    req_valid = 1'b0;
  endtask
  // Random upper byte proves it never reaches the pins
  task automatic start(input logic [7:0] cmd, input logic hold);
    rnd = lfsr(rnd);
    issue(NBI_OP_CMD, 1'b0, {rnd[15:8], cmd});
    for (int i = 0; i < NBI_ADDR_CYCLES; i++) begin
      rnd = lfsr(rnd);
      exp_addr = {rnd[7:0], exp_addr[23:8]};
      issue(NBI_OP_ADDR, hold && i == 2, rnd);
    end
  endtask
  task automatic wait_busy();
    int n;
    n = 0;
    while (busy !== 1'b1 && n < 80) begin
      @(negedge clk_i);
      n++;
    end
    `CHK("busy_seen", 1'b1, busy)
    while (busy !== 1'b0 && n < 200) begin
      @(negedge clk_i);
      n++;
    end
    `CHK("busy_done", 1'b0, busy)
  endtask
  task automatic read_words(input int n, input int lim);
    for (int i = 0; i < n; i++) begin
      exp_q.push_back(pg[i % lim]);
      issue(NBI_OP_RDATA, 1'b0, 16'h0000);
    end
  endtask
  initial begin
    #(400_000);
    miscompares++;
    report_and_stop();
  end
  initial begin
    int n;
    repeat (6) @(posedge clk_i);
    @(negedge clk_i);
    reset_i = 1'b0;
    n = 0;
    while (req_ready !== 1'b1 && n < 300) begin
      `CHK("recovery_pins", 2'b01, {lock_n, ws_n})
      @(negedge clk_i);
      n++;
    end
    `CHK("recovery", 1'b1, n >= NBI_RECOVERY_CYC - 1)
    we = 1'b1;
    foreach (pg[i]) begin
      rnd = lfsr(rnd);
      pg[i] = rnd;
    end
    start(8'h80, 1'b0);
    foreach (pg[i]) issue(NBI_OP_WDATA, 1'b0, pg[i]);
    issue(NBI_OP_CMD, 1'b0, 16'h0010);
    wait_busy();
    `CHK("lock_high", 1'b1, lock_n)
    `CHK("address", exp_addr, i_nbi_flash_model.last_addr)
    foreach (pg[i]) `CHK("array", pg[i], i_nbi_flash_model.mem[i])
    start(8'h00, 1'b1);
    wait_busy();
    fork
      read_words(TOT + 12, TOT);
    join_none
    repeat (400) @(negedge clk_i);
    `CHK("fifo_full", 2'b01, {req_ready, rd_valid})
    stall = 1'b0;
    wait fork;
    spx = 1'b1;
    start(8'h00, 1'b1);
    wait_busy();
    `CHK("spare_pin", 1'b1, spare)
    read_words(MW + 3, MW);
    we = 1'b0;
    start(8'h80, 1'b0);
    repeat (TOT) issue(NBI_OP_WDATA, 1'b0, ~pg[0]);
    issue(NBI_OP_CMD, 1'b0, 16'h0010);
    repeat (60) @(negedge clk_i);
    `CHK("lock_low", 1'b0, lock_n)
    `CHK("no_busy", 1'b0, busy)
    foreach (pg[i]) `CHK("kept", pg[i], i_nbi_flash_model.mem[i])
    extra_busy = 1'b1;
    repeat (3) @(negedge clk_i);
    `CHK("shared_busy", 1'b1, busy)
    extra_busy = 1'b0;
    repeat (3) @(negedge clk_i);
    `CHK("shared_idle", 1'b0, busy)
    n = 0;
    while (exp_q.size() != 0 && n < 1000) begin
      @(negedge clk_i);
      n++;
    end
    `CHK("drained", 0, exp_q.size())
    `CHK("high_byte", 0, i_nbi_flash_model.hi_errs)
    `CHK("odd_cycles", 0, i_nbi_flash_model.odd_cycles)
    `CHK("aborts", 0, i_nbi_flash_model.aborts)
    `CHK("early_cycles", 0, i_nbi_flash_model.early)
    report_and_stop();
  end
endmodule
`default_nettype wire
